// ---- bench/afe_core_sva.sv ----
`timescale 1ns/10ps
module afe_core_sva (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [7:0]  io_evt_i,
  input wire logic [7:0]  io_flag_o,
  input wire logic        busy_o,
  input wire logic [15:0] pc_o
);
  logic       busy_q;
  logic       wr_acc;
  logic       cmd_go;
  logic       flag_go;
  logic [1:0] cmd_n;

  // I/O bit ops are left out: they run two cycles whether or not the address is refused.
  function automatic logic [1:0] n_of(input logic [4:0] op);
    if (op >= afe_pkg::OP_IOSET) begin
      return 2'h0;
    end
    if (op >= afe_pkg::OP_RELATIVE_CALL) begin
      return afe_pkg::CYC_THREE;
    end
    if (op >= afe_pkg::OP_MUL || op == afe_pkg::OP_WADDI || op == afe_pkg::OP_WSUBI) begin
      return afe_pkg::CYC_TWO;
    end
    return afe_pkg::CYC_ONE;
  endfunction

  // A write whose setup cycle saw busy may be refused even if busy fell since.
  always_ff @(posedge clk_i) begin
    busy_q <= busy_o;
  end
  assign wr_acc  = psel_i && penable_i && pwrite_i && pready_o;
  assign cmd_go  = wr_acc && paddr_i == afe_pkg::OFS_CMD && pstrb_i[0] && pwdata_i[7:5] == 3'h0 && !busy_o && !busy_q;
  assign flag_go = wr_acc && paddr_i == {5'h01, afe_pkg::IO_FLAG_IDX, 2'h0} && pstrb_i[0] && !busy_o && !busy_q;
  assign cmd_n   = n_of(pwdata_i[4:0]);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_one;
    cmd_go && cmd_n == afe_pkg::CYC_ONE |=> busy_o ##1 !busy_o;
  endproperty
  a_one: assert property (p_one)
    else $error("byte op busy span wrong");
  property p_two;
    cmd_go && cmd_n == afe_pkg::CYC_TWO |=> busy_o [*2] ##1 !busy_o;
  endproperty
  a_two: assert property (p_two)
    else $error("two cycle op busy span wrong");
  property p_three;
    cmd_go && cmd_n == afe_pkg::CYC_THREE |=> busy_o [*3] ##1 !busy_o;
  endproperty
  a_three: assert property (p_three)
    else $error("call busy span wrong");
  property p_pc_hold;
    !wr_acc && !busy_o |=> $stable(pc_o);
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("pc moved while idle");
  property p_flag_hold;
    !wr_acc && io_evt_i == 8'h00 && !busy_o |=> $stable(io_flag_o);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag register moved without cause");
  property p_evt_set;
    (io_evt_i & afe_pkg::IO_W1C_MASK) != 8'h00
      |=> (io_flag_o & $past(io_evt_i) & afe_pkg::IO_W1C_MASK) == ($past(io_evt_i) & afe_pkg::IO_W1C_MASK);
  endproperty
  a_evt_set: assert property (p_evt_set)
    else $error("event did not set flag");
  property p_w1c;
    flag_go |=> (io_flag_o & $past(pwdata_i[7:0]) & ~$past(io_evt_i) & afe_pkg::IO_W1C_MASK) == 8'h00;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");
  property p_busy_err;
    psel_i && !penable_i && pwrite_i && busy_o ##1 penable_i && busy_o |-> pslverr_o;
  endproperty
  a_busy_err: assert property (p_busy_err)
    else $error("write while busy not refused");
  property p_unmapped;
    psel_i && penable_i && paddr_i[11:7] == 5'h00 && paddr_i > afe_pkg::OFS_RET |-> pslverr_o;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  c_one: cover property (cmd_go && cmd_n == afe_pkg::CYC_ONE);
  c_three: cover property (cmd_go && cmd_n == afe_pkg::CYC_THREE);
  c_err: cover property (pslverr_o);
  c_evt: cover property (io_flag_o[7]);
endmodule

bind afe_core afe_core_sva i_afe_core_sva (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .io_evt_i, .io_flag_o, .busy_o, .pc_o);

// ---- bench/afe_evt_model.sv ----
`timescale 1ns/10ps
module afe_evt_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] fire_i,
  output logic      [7:0] evt_o
);
  // Peripheral raises flags.
  // Only the clear-on-one bits have a hardware source, so others stay low.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      evt_o <= 8'h00;
    end else begin
      evt_o <= fire_i & afe_pkg::IO_W1C_MASK;
    end
  end
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [4:0]  op;
    logic [23:0] opd;
    logic [5:0]  fin;
    logic [15:0] res;
    logic [5:0]  fout;
  } afe_row_t;
  typedef struct packed {
    logic [4:0]  op;
    logic [15:0] pc0;
    logic [15:0] z;
    logic [7:0]  off;
    logic [15:0] pcx;
  } afe_jrow_t;

  // Flags are {h,s,v,n,z,c}; seeded flags show that unlisted ones are kept.
  localparam afe_row_t ALU [25] = '{
    {5'h00, 24'h00017f, 6'h10, 16'h0080, 6'h3c},
    {5'h01, 24'h0000ff, 6'h01, 16'h0000, 6'h23},
    {5'h03, 24'h000110, 6'h00, 16'h000f, 6'h20},
    {5'h04, 24'h000180, 6'h00, 16'h007f, 6'h28},
    {5'h05, 24'h000000, 6'h01, 16'h00ff, 6'h25},
    {5'h06, 24'h000305, 6'h11, 16'h0001, 6'h10},
    {5'h08, 24'h000ff0, 6'h3f, 16'h0000, 6'h33},
    {5'h09, 24'h008081, 6'h08, 16'h0080, 6'h04},
    {5'h0a, 24'h000000, 6'h04, 16'h0000, 6'h02},
    {5'h0b, 24'h008040, 6'h21, 16'h00c0, 6'h25},
    {5'h0c, 24'h000fff, 6'h00, 16'h00f0, 6'h04},
    {5'h0d, 24'h000055, 6'h20, 16'h00aa, 6'h25},
    {5'h0e, 24'h000080, 6'h10, 16'h0080, 6'h1d},
    {5'h0f, 24'h00f001, 6'h00, 16'h00f1, 6'h04},
    {5'h10, 24'h000fff, 6'h3f, 16'h00f0, 6'h35},
    {5'h11, 24'h000000, 6'h0d, 16'h0000, 6'h03},
    {5'h12, 24'h00005a, 6'h04, 16'h0000, 6'h02},
    {5'h13, 24'h000012, 6'h2b, 16'h00ff, 6'h2b},
    {5'h02, 24'h0001ff, 6'h20, 16'h0100, 6'h20},
    {5'h02, 24'h7f3fff, 6'h00, 16'h803e, 6'h0c},
    {5'h07, 24'h000100, 6'h00, 16'hffff, 6'h15},
    {5'h14, 24'h00ffff, 6'h3c, 16'hfe01, 6'h3d},
    {5'h15, 24'h008080, 6'h01, 16'h4000, 6'h00},
    {5'h16, 24'h0002ff, 6'h00, 16'hfffe, 6'h01},
    {5'h17, 24'h008080, 6'h02, 16'h8000, 6'h00}
  };
  localparam afe_jrow_t JMP [4] = '{
    {5'h1a, 16'h0010, 16'h0000, 8'hfe, 16'h000f},
    {5'h1c, 16'h0100, 16'h0000, 8'h7f, 16'h0180},
    {5'h1b, 16'h0000, 16'h1234, 8'h00, 16'h1234},
    {5'h1d, 16'h1234, 16'habcd, 8'h00, 16'habcd}
  };
  localparam logic [11:0] FLAG_ADR = {5'h01, afe_pkg::IO_FLAG_IDX, 2'h0};

  logic        clk_i;
  logic        resetn_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0]  pstrb_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [7:0]  io_evt_i;
  logic [7:0]  io_flag_o;
  logic        busy_o;
  logic [15:0] pc_o;
  logic [7:0]  fire;
  int          n_fail;
  int          n_tests;

  afe_core i_afe_core (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .io_evt_i, .io_flag_o, .busy_o, .pc_o);
  afe_evt_model i_afe_evt_model (.clk_i, .resetn_i, .fire_i(fire), .evt_o(io_evt_i));

  task conclude;
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) begin
      @(posedge clk_i);
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task go(input logic [4:0] op);
    int n;
    wr(afe_pkg::OFS_CMD, {27'h0, op});
    n = 0;
    repeat (2) @(posedge clk_i);
    while (busy_o !== 1'b0 && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    chk("busy", 32'h0, {31'h0, busy_o});
  endtask

  task pulse(input logic [7:0] m);
    @(posedge clk_i);
    fire <= m;
    @(posedge clk_i);
    fire <= 8'h00;
    repeat (2) @(posedge clk_i);
  endtask

  task t_alu;
    logic [31:0] r;
    logic [31:0] m;
    for (int i = 0; i < 25; i++) begin
      wr(afe_pkg::OFS_FLAGS, {26'h0, ALU[i].fin});
      wr(afe_pkg::OFS_OPND, {8'h00, ALU[i].opd});
      go(ALU[i].op);
      rd(afe_pkg::OFS_RESULT, r);
      chk("result", {16'h0, ALU[i].res}, r);
      rd(afe_pkg::OFS_FLAGS, r);
      // Carry after a one's complement is left open, so it is masked.
      m = (ALU[i].op == afe_pkg::OP_COM) ? 32'h3e : 32'h3f;
      chk("flags", {26'h0, ALU[i].fout} & m, r & m);
    end
  endtask

  task t_jump;
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      wr(afe_pkg::OFS_PC, {16'h0, JMP[i].pc0});
      wr(afe_pkg::OFS_ZPTR, {16'h0, JMP[i].z});
      wr(afe_pkg::OFS_OPND, {JMP[i].off, 24'h0});
      wr(afe_pkg::OFS_FLAGS, 32'h2a);
      go(JMP[i].op);
      chk("pc", {16'h0, JMP[i].pcx}, {16'h0, pc_o});
      rd(afe_pkg::OFS_FLAGS, r);
      chk("jump flags", 32'h2a, r);
      if (JMP[i].op[2]) begin
        rd(afe_pkg::OFS_RET, r);
        chk("return", {16'h0, JMP[i].pc0 + 16'h1}, r);
      end
    end
  endtask

  task t_io;
    logic [31:0] r;
    wr(12'h094, 32'ha5);
    wr(afe_pkg::OFS_OPND, 32'h0501);
    go(afe_pkg::OP_IOSET);
    rd(12'h094, r);
    chk("io set", 32'ha7, r);
    wr(afe_pkg::OFS_OPND, 32'h0507);
    go(afe_pkg::OP_IOCLR);
    rd(12'h094, r);
    chk("io clear", 32'h27, r);
    pulse(8'hc0);
    chk("event", 32'hc0, {24'h0, io_flag_o});
    wr(afe_pkg::OFS_OPND, {16'h0, 3'h0, afe_pkg::IO_FLAG_IDX, 8'h00});
    go(afe_pkg::OP_IOSET);
    chk("rmw clears", 32'h01, {24'h0, io_flag_o});
    pulse(8'h40);
    wr(FLAG_ADR, 32'h41);
    @(negedge clk_i);
    chk("write one", 32'h01, {24'h0, io_flag_o});
    wr(afe_pkg::OFS_OPND, 32'h2003);
    go(afe_pkg::OP_IOSET);
    rd(afe_pkg::OFS_STATUS, r);
    chk("io range", 32'h4, r);
    rd(12'h080, r);
    chk("io alias", 32'h0, r);
  endtask

  task t_refuse;
    logic [31:0] r;
    logic        e;
    wr(afe_pkg::OFS_FLAGS, 32'h0);
    wr(afe_pkg::OFS_CMD, {27'h0, afe_pkg::OP_INDIRECT_CALL});
    apb(1'b1, afe_pkg::OFS_FLAGS, 32'h3f, r, e);
    chk("busy write err", 32'h1, {31'h0, e});
    repeat (4) @(posedge clk_i);
    rd(afe_pkg::OFS_FLAGS, r);
    chk("busy write lost", 32'h0, r);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    wr(afe_pkg::OFS_CMD, 32'he0);
    @(negedge clk_i);
    chk("bad op idle", 32'h0, {31'h0, busy_o});
    rd(afe_pkg::OFS_STATUS, r);
    // The address error of the I/O range case stays until the next valid I/O op.
    chk("bad op status", 32'h6, r);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    conclude;
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    resetn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pstrb_i = 4'hf;
    fire = 8'h00;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    chk("reset pc", 32'h0, {16'h0, pc_o});
    chk("reset flag", 32'h0, {24'h0, io_flag_o});
    t_alu;
    t_jump;
    t_io;
    t_refuse;
    conclude;
  end
endmodule

// ---- hw/afe_core.sv ----
`timescale 1ns/10ps
module afe_core (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [7:0]  io_evt_i,
  output logic      [7:0]  io_flag_o,
  output logic             busy_o,
  output logic      [15:0] pc_o
);
  afe_pkg::afe_state_t state_q;
  afe_pkg::afe_state_t state_d;
  afe_pkg::afe_op_t    op_q;
  afe_pkg::afe_opnd_t  opnd_q;
  afe_pkg::afe_flags_t flags_q;
  afe_pkg::afe_flags_t f_d;
  afe_pkg::afe_rmw_t   rmw;
  logic [15:0] pc_q;
  logic [15:0] zptr_q;
  logic [15:0] res_q;
  logic [15:0] ret_q;
  logic [1:0]  cnt_q;
  logic        badop_q;
  logic        ioerr_q;
  logic [31:0] prdata_q;
  logic        err_q;

  logic        setup;
  logic        access;
  logic        is_io;
  logic        reg_hit;
  logic        wr_ok;
  logic        start;
  logic        commit;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [7:0]  io_rdata;

  logic [7:0]  rd;
  logic [7:0]  k;
  logic        cin_add;
  logic        cin_sub;
  logic [7:0]  sub_a;
  logic [7:0]  sub_b;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [8:0]  dif9;
  logic [4:0]  dif5;
  logic [15:0] word;
  logic [15:0] wsum;
  logic [15:0] wdif;
  logic [7:0]  lres;
  logic [15:0] mprod;
  logic        mcarry;
  logic        mzero;
  logic        msign_a;
  logic        msign_b;
  logic        mfrac;
  logic [15:0] res_d;
  logic        res_wr;
  logic [15:0] pc_d;
  logic        pc_wr;
  logic        ret_wr;
  logic        io_bad;

  assign setup   = psel_i && !penable_i;
  assign access  = psel_i && penable_i;
  assign is_io   = paddr_i[afe_pkg::IO_WIN_BIT];
  assign reg_hit = !is_io && (paddr_i[11:5] == 7'h00) && (paddr_i[1:0] == 2'h0);
  // Writes are refused while an operation runs, so the bus never races the datapath.
  assign wr_ok   = access && pwrite_i && (reg_hit || is_io) && (state_q == afe_pkg::ST_IDLE) && !err_q;
  assign start   = wr_ok && reg_hit && (paddr_i == afe_pkg::OFS_CMD) && pstrb_i[0];
  assign commit  = (state_q == afe_pkg::ST_RUN) && (cnt_q == 2'h1);
  assign wmask   = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

  assign pready_o  = 1'b1;
  assign pslverr_o = access && err_q;
  assign prdata_o  = prdata_q;
  assign busy_o    = (state_q == afe_pkg::ST_RUN);
  assign pc_o      = pc_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      afe_pkg::OFS_CMD:    rd_mux = {27'h000_0000, op_q};
      afe_pkg::OFS_OPND:   rd_mux = opnd_q;
      afe_pkg::OFS_PC:     rd_mux = {16'h0000, pc_q};
      afe_pkg::OFS_ZPTR:   rd_mux = {16'h0000, zptr_q};
      afe_pkg::OFS_RESULT: rd_mux = {16'h0000, res_q};
      afe_pkg::OFS_FLAGS:  rd_mux = {26'h000_0000, flags_q};
      afe_pkg::OFS_STATUS: rd_mux = {29'h0000_0000, ioerr_q, badop_q, busy_o};
      afe_pkg::OFS_RET:    rd_mux = {16'h0000, ret_q};
      default:             rd_mux = 32'h0000_0000;
    endcase
    if (is_io) begin
      rd_mux = {24'h00_0000, io_rdata};
    end
  end

  // Read data and the error answer are settled in the setup cycle.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite_i ? 32'h0000_0000 : rd_mux;
      err_q    <= !(reg_hit || is_io) || (pwrite_i && (state_q != afe_pkg::ST_IDLE));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      opnd_q <= afe_pkg::OPND_RST;
      zptr_q <= afe_pkg::ZPTR_RST;
    end else if (wr_ok && reg_hit) begin
      if (paddr_i == afe_pkg::OFS_OPND) begin
        opnd_q <= (opnd_q & ~wmask) | (pwdata_i & wmask);
      end
      if (paddr_i == afe_pkg::OFS_ZPTR) begin
        zptr_q <= (zptr_q & ~wmask[15:0]) | (pwdata_i[15:0] & wmask[15:0]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      op_q    <= afe_pkg::OP_ADD;
      badop_q <= 1'b0;
    end else if (start) begin
      op_q    <= afe_pkg::afe_op_t'(pwdata_i[4:0]);
      badop_q <= (pwdata_i[7:5] != 3'h0);
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      afe_pkg::ST_IDLE: begin
        if (start && (pwdata_i[7:5] == 3'h0)) begin
          state_d = afe_pkg::ST_RUN;
        end
      end
      afe_pkg::ST_RUN: begin
        if (commit) begin
          state_d = afe_pkg::ST_IDLE;
        end
      end
      default: state_d = afe_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_q <= afe_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_q <= 2'h0;
    end else if (state_q == afe_pkg::ST_IDLE && state_d == afe_pkg::ST_RUN) begin
      case (afe_pkg::afe_op_t'(pwdata_i[4:0]))
        afe_pkg::OP_WADDI, afe_pkg::OP_WSUBI, afe_pkg::OP_MUL, afe_pkg::OP_SIGNED_MULTIPLY,
        afe_pkg::OP_MIXED_SIGN_MULTIPLY, afe_pkg::OP_FRACTIONAL_UNSIGNED_MULTIPLY, afe_pkg::OP_FRACTIONAL_SIGNED_MULTIPLY, afe_pkg::OP_FRACTIONAL_MIXED_MULTIPLY,
        afe_pkg::OP_RELATIVE_JUMP, afe_pkg::OP_INDIRECT_JUMP, afe_pkg::OP_IOSET, afe_pkg::OP_IOCLR:
          cnt_q <= afe_pkg::CYC_TWO;
        afe_pkg::OP_RELATIVE_CALL, afe_pkg::OP_INDIRECT_CALL:
          cnt_q <= afe_pkg::CYC_THREE;
        default:
          cnt_q <= afe_pkg::CYC_ONE;
      endcase
    end else if (state_q == afe_pkg::ST_RUN) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  assign rd   = opnd_q.rd;
  assign k    = opnd_q.k;
  assign word = {opnd_q.rdh, opnd_q.rd};

  assign cin_sub = ((op_q == afe_pkg::OP_SBC) || (op_q == afe_pkg::OP_SUBTRACT_IMMEDIATE_WITH_CARRY)) && flags_q.c;
  assign cin_add = (op_q == afe_pkg::OP_ADC) && flags_q.c;
  assign sub_a = (op_q == afe_pkg::OP_NEG) ? 8'h00 : rd;
  assign sub_b = (op_q == afe_pkg::OP_NEG) ? rd : k;

  assign sum9 = {1'b0, rd} + {1'b0, k} + {8'h00, cin_add};
  assign sum5 = {1'b0, rd[3:0]} + {1'b0, k[3:0]} + {4'h0, cin_add};
  assign dif9 = {1'b0, sub_a} - {1'b0, sub_b} - {8'h00, cin_sub};
  assign dif5 = {1'b0, sub_a[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, cin_sub};
  assign wsum = word + {10'h000, k[5:0]};
  assign wdif = word - {10'h000, k[5:0]};

  assign msign_a = (op_q == afe_pkg::OP_SIGNED_MULTIPLY) || (op_q == afe_pkg::OP_MIXED_SIGN_MULTIPLY) ||
                   (op_q == afe_pkg::OP_FRACTIONAL_SIGNED_MULTIPLY) || (op_q == afe_pkg::OP_FRACTIONAL_MIXED_MULTIPLY);
  assign msign_b = (op_q == afe_pkg::OP_SIGNED_MULTIPLY) || (op_q == afe_pkg::OP_FRACTIONAL_SIGNED_MULTIPLY);
  assign mfrac   = (op_q == afe_pkg::OP_FRACTIONAL_UNSIGNED_MULTIPLY) || (op_q == afe_pkg::OP_FRACTIONAL_SIGNED_MULTIPLY) ||
                   (op_q == afe_pkg::OP_FRACTIONAL_MIXED_MULTIPLY);

  afe_mul u_mul (
    .a_i      (rd),
    .b_i      (k),
    .sign_a_i (msign_a),
    .sign_b_i (msign_b),
    .frac_i   (mfrac),
    .prod_o   (mprod),
    .carry_o  (mcarry),
    .zero_o   (mzero)
  );

  assign io_bad = (k[5:0] > afe_pkg::IO_LAST_ADDR) || (k[7:6] != 2'h0);

  always_comb begin
    f_d    = flags_q;
    lres   = 8'h00;
    res_d  = res_q;
    res_wr = 1'b0;
    pc_d   = pc_q;
    pc_wr  = 1'b0;
    ret_wr = 1'b0;
    rmw    = '0;
    case (op_q)
      afe_pkg::OP_ADD, afe_pkg::OP_ADC: begin
        res_d  = {8'h00, sum9[7:0]};
        res_wr = 1'b1;
        f_d.c  = sum9[8];
        f_d.h  = sum5[4];
        f_d.v  = (rd[7] == k[7]) && (sum9[7] != rd[7]);
      end
      afe_pkg::OP_SUB, afe_pkg::OP_SUBTRACT_IMMEDIATE, afe_pkg::OP_SBC, afe_pkg::OP_SUBTRACT_IMMEDIATE_WITH_CARRY, afe_pkg::OP_NEG: begin
        res_d  = {8'h00, dif9[7:0]};
        res_wr = 1'b1;
        f_d.c  = dif9[8];
        f_d.h  = dif5[4];
        f_d.v  = (sub_a[7] != sub_b[7]) && (dif9[7] != sub_a[7]);
      end
      afe_pkg::OP_WADDI: begin
        res_d  = wsum;
        res_wr = 1'b1;
        f_d.v  = !word[15] && wsum[15];
        f_d.c  = !wsum[15] && word[15];
      end
      afe_pkg::OP_WSUBI: begin
        res_d  = wdif;
        res_wr = 1'b1;
        f_d.v  = word[15] && !wdif[15];
        f_d.c  = wdif[15] && !word[15];
      end
      afe_pkg::OP_AND, afe_pkg::OP_ANDI, afe_pkg::OP_OR, afe_pkg::OP_ORI, afe_pkg::OP_SBR,
      afe_pkg::OP_EOR, afe_pkg::OP_CBR, afe_pkg::OP_TST, afe_pkg::OP_CLR, afe_pkg::OP_COM: begin
        case (op_q)
          afe_pkg::OP_AND, afe_pkg::OP_ANDI: lres = rd & k;
          afe_pkg::OP_OR, afe_pkg::OP_ORI, afe_pkg::OP_SBR: lres = rd | k;
          afe_pkg::OP_EOR: lres = rd ^ k;
          afe_pkg::OP_CBR: lres = rd & (8'hff - k);
          afe_pkg::OP_TST: lres = rd & rd;
          afe_pkg::OP_CLR: lres = rd ^ rd;
          default: lres = 8'hff - rd;
        endcase
        res_d  = {8'h00, lres};
        res_wr = 1'b1;
        f_d.v  = 1'b0;
        if (op_q == afe_pkg::OP_COM) begin
          f_d.c = 1'b1;
        end
      end
      afe_pkg::OP_SER: begin
        res_d  = 16'h00ff;
        res_wr = 1'b1;
      end
      afe_pkg::OP_MUL, afe_pkg::OP_SIGNED_MULTIPLY, afe_pkg::OP_MIXED_SIGN_MULTIPLY,
      afe_pkg::OP_FRACTIONAL_UNSIGNED_MULTIPLY, afe_pkg::OP_FRACTIONAL_SIGNED_MULTIPLY, afe_pkg::OP_FRACTIONAL_MIXED_MULTIPLY: begin
        res_d  = mprod;
        res_wr = 1'b1;
        f_d.c  = mcarry;
        f_d.z  = mzero;
      end
      afe_pkg::OP_RELATIVE_JUMP, afe_pkg::OP_RELATIVE_CALL: begin
        pc_d   = pc_q + {{8{opnd_q.offset[7]}}, opnd_q.offset} + 16'h0001;
        pc_wr  = 1'b1;
        ret_wr = (op_q == afe_pkg::OP_RELATIVE_CALL);
      end
      afe_pkg::OP_INDIRECT_JUMP, afe_pkg::OP_INDIRECT_CALL: begin
        pc_d   = zptr_q;
        pc_wr  = 1'b1;
        ret_wr = (op_q == afe_pkg::OP_INDIRECT_CALL);
      end
      afe_pkg::OP_IOSET, afe_pkg::OP_IOCLR: begin
        rmw.en   = commit && !io_bad;
        rmw.idx  = k[4:0];
        rmw.bitn = rd[2:0];
        rmw.set  = (op_q == afe_pkg::OP_IOSET);
      end
      default: begin
        res_wr = 1'b0;
      end
    endcase
    if (res_wr && (op_q != afe_pkg::OP_SER) && !mfrac && (op_q != afe_pkg::OP_MUL) &&
        (op_q != afe_pkg::OP_SIGNED_MULTIPLY) && (op_q != afe_pkg::OP_MIXED_SIGN_MULTIPLY)) begin
      if ((op_q == afe_pkg::OP_WADDI) || (op_q == afe_pkg::OP_WSUBI)) begin
        f_d.z = (res_d == 16'h0000);
        f_d.n = res_d[15];
        f_d.s = res_d[15] ^ f_d.v;
      end else begin
        f_d.z = (res_d[7:0] == 8'h00);
        f_d.n = res_d[7];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      flags_q <= afe_pkg::FLAGS_RST;
    end else if (commit) begin
      flags_q <= f_d;
    end else if (wr_ok && reg_hit && (paddr_i == afe_pkg::OFS_FLAGS) && pstrb_i[0]) begin
      flags_q <= pwdata_i[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      res_q <= 16'h0000;
    end else if (commit && res_wr) begin
      res_q <= res_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pc_q  <= afe_pkg::PC_RST;
      ret_q <= 16'h0000;
    end else if (commit && pc_wr) begin
      pc_q <= pc_d;
      if (ret_wr) begin
        ret_q <= pc_q + 16'h0001;
      end
    end else if (wr_ok && reg_hit && (paddr_i == afe_pkg::OFS_PC)) begin
      pc_q <= (pc_q & ~wmask[15:0]) | (pwdata_i[15:0] & wmask[15:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ioerr_q <= 1'b0;
    end else if (commit && ((op_q == afe_pkg::OP_IOSET) || (op_q == afe_pkg::OP_IOCLR))) begin
      ioerr_q <= io_bad;
    end
  end

  afe_io u_io (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (wr_ok && is_io && pstrb_i[0]),
    .wr_idx_i  (paddr_i[6:2]),
    .wr_data_i (pwdata_i[7:0]),
    .rd_idx_i  (paddr_i[6:2]),
    .rd_data_o (io_rdata),
    .rmw_i     (rmw),
    .evt_i     (io_evt_i),
    .flag_o    (io_flag_o)
  );
endmodule

// ---- hw/afe_io.sv ----
`timescale 1ns/10ps
module afe_io (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             wr_en_i,
  input  wire logic [4:0]       wr_idx_i,
  input  wire logic [7:0]       wr_data_i,
  input  wire logic [4:0]       rd_idx_i,
  output logic      [7:0]       rd_data_o,
  input  wire afe_pkg::afe_rmw_t rmw_i,
  input  wire logic [7:0]       evt_i,
  output logic      [7:0]       flag_o
);
  logic [7:0] mem_q [32];
  logic [7:0] rmw_old;
  logic [7:0] rmw_val;

  assign rd_data_o = mem_q[rd_idx_i];
  assign flag_o    = mem_q[afe_pkg::IO_FLAG_IDX];
  assign rmw_old   = mem_q[rmw_i.idx];

  always_comb begin
    rmw_val = rmw_old;
    rmw_val[rmw_i.bitn] = rmw_i.set;
  end

  for (genvar i = 0; i < 32; i++) begin : g_ent
    localparam logic [7:0] MASK = (i == int'(afe_pkg::IO_FLAG_IDX)) ? afe_pkg::IO_W1C_MASK : 8'h00;
    logic       hit_w;
    logic       hit_r;
    logic [7:0] wval;
    logic [7:0] d;
    assign hit_w = wr_en_i && (wr_idx_i == 5'(i));
    assign hit_r = rmw_i.en && (rmw_i.idx == 5'(i));
    assign wval  = hit_r ? rmw_val : wr_data_i;
    always_comb begin
      d = mem_q[i];
      if (hit_w || hit_r) begin
        d = (wval & ~MASK) | (mem_q[i] & MASK & ~wval);
      end
      // An event in the same cycle as its clear is kept.
      d = d | (evt_i & MASK);
    end
    always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
        mem_q[i] <= 8'h00;
      end else begin
        mem_q[i] <= d;
      end
    end
  end
endmodule

// ---- hw/afe_mul.sv ----
`timescale 1ns/10ps
module afe_mul (
  input  wire logic [7:0]  a_i,
  input  wire logic [7:0]  b_i,
  input  wire logic        sign_a_i,
  input  wire logic        sign_b_i,
  input  wire logic        frac_i,
  output logic      [15:0] prod_o,
  output logic             carry_o,
  output logic             zero_o
);
  logic signed [8:0]  ext_a;
  logic signed [8:0]  ext_b;
  logic signed [17:0] full;
  logic        [15:0] raw;

  // Extending by one bit lets one signed multiplier serve all three sign mixes.
  assign ext_a = signed'({sign_a_i & a_i[7], a_i});
  assign ext_b = signed'({sign_b_i & b_i[7], b_i});
  assign full  = ext_a * ext_b;
  assign raw   = full[15:0];
  assign carry_o = raw[15];
  assign prod_o = frac_i ? {raw[14:0], 1'b0} : raw;
  assign zero_o = (prod_o == 16'h0000);
endmodule

// ---- hw/afe_pkg.sv ----
package afe_pkg;

  localparam logic [11:0] OFS_CMD    = 12'h000;
  localparam logic [11:0] OFS_OPND   = 12'h004;
  localparam logic [11:0] OFS_PC     = 12'h008;
  localparam logic [11:0] OFS_ZPTR   = 12'h00c;
  localparam logic [11:0] OFS_RESULT = 12'h010;
  localparam logic [11:0] OFS_FLAGS  = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;
  localparam logic [11:0] OFS_RET    = 12'h01c;
  localparam int          IO_WIN_BIT = 7;

  localparam int OPND_RD_LSB  = 0;
  localparam int OPND_K_LSB   = 8;
  localparam int OPND_RDH_LSB = 16;
  localparam int OPND_OFF_LSB = 24;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_BADOP   = 1;
  localparam int STAT_IOERR   = 2;

  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [15:0] ZPTR_RST  = 16'h0000;
  localparam logic [31:0] OPND_RST  = 32'h0000_0000;
  localparam logic [5:0]  FLAGS_RST = 6'h00;

  localparam logic [4:0] IO_FLAG_IDX  = 5'h0e;
  localparam logic [7:0] IO_W1C_MASK  = 8'hc0;
  localparam logic [5:0] IO_LAST_ADDR = 6'h1f;

  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } afe_flags_t;

  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] rdh;
    logic [7:0] k;
    logic [7:0] rd;
  } afe_opnd_t;

  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_ADC = 5'h01, OP_WADDI = 5'h02, OP_SUB = 5'h03,
    OP_SUBTRACT_IMMEDIATE = 5'h04, OP_SBC = 5'h05, OP_SUBTRACT_IMMEDIATE_WITH_CARRY = 5'h06, OP_WSUBI = 5'h07,
    OP_AND = 5'h08, OP_ANDI = 5'h09, OP_OR = 5'h0a, OP_ORI = 5'h0b,
    OP_EOR = 5'h0c, OP_COM = 5'h0d, OP_NEG = 5'h0e, OP_SBR = 5'h0f,
    OP_CBR = 5'h10, OP_TST = 5'h11, OP_CLR = 5'h12, OP_SER = 5'h13,
    OP_MUL = 5'h14, OP_SIGNED_MULTIPLY = 5'h15, OP_MIXED_SIGN_MULTIPLY = 5'h16, OP_FRACTIONAL_UNSIGNED_MULTIPLY = 5'h17,
    OP_FRACTIONAL_SIGNED_MULTIPLY = 5'h18, OP_FRACTIONAL_MIXED_MULTIPLY = 5'h19, OP_RELATIVE_JUMP = 5'h1a, OP_INDIRECT_JUMP = 5'h1b,
    OP_RELATIVE_CALL = 5'h1c, OP_INDIRECT_CALL = 5'h1d, OP_IOSET = 5'h1e, OP_IOCLR = 5'h1f
  } afe_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } afe_state_t;

  typedef struct packed {
    logic       en;
    logic [4:0] idx;
    logic [2:0] bitn;
    logic       set;
  } afe_rmw_t;

endpackage
